// ### wdog_counter.sv
/*
 * timeout counter: counts oscillator ticks up to the length chosen
 * by the timeout select code and pulses timeout for one cycle.
 * assumes tick, run and restart are synchronous to pclk.
 */
`timescale 1ns/100ps
module wdog_counter
	import wdog_pkg::*;
#(
	parameter int SW = SEL_W,
	parameter int CW = CNT_W
)(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          tick,
	input  wire logic          run,
	input  wire logic          restart,
	input  wire logic [SW-1:0] sel,
	output logic               timeout
);

	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic          next_timeout;
	logic [SW-1:0] sel_eff;
	logic [CW-1:0] last;

	// reserved codes behave as the longest defined code
	always_comb
	begin
		sel_eff = (sel > SEL_MAX) ? SEL_MAX : sel;
		last = (CW'(1) << (CW'(BASE_LOG2) + CW'(sel_eff))) - CW'(1);
		next_count = count;
		next_timeout = 1'b0;
		if (!run || restart)
		begin
			next_count = '0;
		end
		else if (tick)
		begin
			// >= so a shorter select times out at once
			if (count >= last)
			begin
				next_count = '0;
				next_timeout = 1'b1;
			end
			else
			begin
				next_count = count + CW'(1);
			end
		end
	end

	// counter registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count <= '0;
			timeout <= 1'b0;
		end
		else
		begin
			count <= next_count;
			timeout <= next_timeout;
		end
	end

endmodule

// ### wdog_cpu_model.sv
/*
 cpu side: runs the watchdog vector after lat cycles.
 assumes timeout_irq is a level on pclk.
*/
`timescale 1ns/100ps
module wdog_cpu_model (
	input wire logic	pclk,
	input wire logic	presetn,
	input wire logic	timeout_irq,
	input wire logic	service,
	input wire logic [7:0]	lat,
	output logic	vector_ack
);
	logic [7:0]	wait_count;
	// one vector per request; 8'hff waits for the request to drop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wait_count <= 8'h00;
			vector_ack <= 1'b0;
		end
		else
		begin
			vector_ack <= 1'b0;
			if (!timeout_irq || !service)
				wait_count <= 8'h00;
			else if (wait_count == lat)
			begin
				vector_ack <= 1'b1;
				wait_count <= 8'hff;
			end
			else if (wait_count != 8'hff)
				wait_count <= wait_count + 8'h01;
		end
	end
endmodule

// ### wdog_pkg.sv
/*
 * constants, field positions and carrier types for the watchdog
 * control and reset-cause block.
 * assumes a 32-bit apb slave port and a 250 mhz pclk.
 */
package wdog_pkg;

	// apb register map (byte addresses)
	localparam int          ADDR_W      = 12;
	localparam logic [11:0] CTRL_ADDR   = 12'h060;
	localparam logic [11:0] CAUSE_ADDR  = 12'h064;

	// control register field positions
	localparam int IRQ_FLAG_BIT  = 7;
	localparam int IRQ_EN_BIT    = 6;
	localparam int SEL_HI_BIT    = 5;
	localparam int UNLOCK_BIT    = 4;
	localparam int RST_EN_BIT    = 3;
	localparam int SEL_LO_MSB    = 2;

	// reset-cause register field positions
	localparam int JTAG_BIT      = 4;
	localparam int DOG_BIT       = 3;
	localparam int BROWN_BIT     = 2;
	localparam int PIN_BIT       = 1;
	localparam int PWRON_BIT     = 0;
	localparam logic [4:0] CAUSE_RESET = 5'h01;

	// timing
	localparam int CLK_HZ        = 250000000;
	localparam int OSC_HZ        = 128000;
	localparam int OSC_DIV       = CLK_HZ / OSC_HZ;
	localparam int UNLOCK_CYCLES = 4;

	// timeout select
	localparam int         SEL_W     = 4;
	localparam logic [3:0] SEL_MAX   = 4'h9;
	localparam int         BASE_LOG2 = 11;
	localparam int         CNT_W     = 21;

	// reset events reported by the system reset controller
	typedef struct packed {
		logic jtag;
		logic brownout;
		logic pin;
	} reset_event_t;

	// stored control fields
	typedef struct packed {
		logic             irq_flag;
		logic             irq_enable;
		logic             reset_enable;
		logic [SEL_W-1:0] timeout_select;
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = '0;

endpackage

// ### wdog_top.sv
/*
 * watchdog control register, reset-cause register and timeout
 * actions, reached over apb.
 * assumes presetn is the power-on reset, reset events, vector
 * acknowledge and restart are one-cycle pulses on pclk, and the
 * always-on fuse is a static level.
 */
`timescale 1ns/100ps
module wdog_top
	import wdog_pkg::*;
#(
	parameter int DIV = OSC_DIV
)(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [ADDR_W-1:0]    paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 always_on_fuse,
	input  wire logic                 global_irq_enable,
	input  wire logic                 vector_ack,
	input  wire logic                 restart,
	input  wire wdog_pkg::reset_event_t reset_event,
	output logic                      timeout_irq,
	output logic                      dog_system_reset
);
	import wdog_pkg::*;

	////////////////////////////////////////////////////////////////
	// declarations
	////////////////////////////////////////////////////////////////

	ctrl_t        ctrl;
	ctrl_t        next_ctrl;
	logic [4:0]   cause;
	logic [4:0]   next_cause;
	logic [2:0]   unlock_count;
	logic [2:0]   next_unlock_count;
	logic [11:0]  div_count;
	logic [11:0]  next_div_count;
	logic         osc_tick;
	logic         next_osc_tick;
	logic [31:0]  next_prdata;
	logic         next_pready;
	logic         next_pslverr;
	logic         next_timeout_irq;
	logic         next_dog_system_reset;
	logic         timeout;
	logic         unlocked;
	logic         rst_en_eff;
	logic         irq_en_eff;
	logic         do_irq;
	logic         do_reset;
	logic         any_reset;
	logic         wr_done;
	logic         wr_ctrl;
	logic         wr_cause;
	logic         setup;
	logic         hit_ctrl;
	logic         hit_cause;
	logic [7:0]   wd;
	logic [7:0]   ctrl_view;

	////////////////////////////////////////////////////////////////
	// effective mode and timeout actions
	////////////////////////////////////////////////////////////////

	// fuse overrides both stored enables; watchdog flag overrides the stored reset enable only
	always_comb
	begin
		rst_en_eff = ctrl.reset_enable | cause[DOG_BIT] | always_on_fuse;
		irq_en_eff = ctrl.irq_enable & ~always_on_fuse;
		unlocked = (unlock_count != 3'h0);
	end

	// interrupt, interrupt-then-reset, reset or stopped
	always_comb
	begin
		do_irq = timeout & irq_en_eff & ~(rst_en_eff & ctrl.irq_flag);
		do_reset = timeout & rst_en_eff & (~irq_en_eff | ctrl.irq_flag);
		any_reset = do_reset | reset_event.jtag | reset_event.brownout
			| reset_event.pin;
	end

	////////////////////////////////////////////////////////////////
	// oscillator tick divider
	////////////////////////////////////////////////////////////////

	// one-cycle enable at the watchdog oscillator rate
	always_comb
	begin
		next_osc_tick = 1'b0;
		next_div_count = div_count + 12'h001;
		if (div_count >= 12'(DIV - 1))
		begin
			next_div_count = 12'h000;
			next_osc_tick = 1'b1;
		end
	end

	// divider registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_count <= 12'h000;
			osc_tick <= 1'b0;
		end
		else
		begin
			div_count <= next_div_count;
			osc_tick <= next_osc_tick;
		end
	end

	////////////////////////////////////////////////////////////////
	// timeout counter
	////////////////////////////////////////////////////////////////

	// counter runs whenever any mode is active
	wdog_counter #(
		.SW (SEL_W),
		.CW (CNT_W)
	) u_counter (
		.pclk    (pclk),
		.presetn (presetn),
		.tick    (osc_tick),
		.run     (rst_en_eff | irq_en_eff),
		.restart (restart | any_reset),
		.sel     (ctrl.timeout_select),
		.timeout (timeout)
	);

	////////////////////////////////////////////////////////////////
	// apb decode and read path
	////////////////////////////////////////////////////////////////

	// decode and write strobes at the completing edge
	always_comb
	begin
		setup = psel & ~penable;
		hit_ctrl = (paddr == CTRL_ADDR);
		hit_cause = (paddr == CAUSE_ADDR);
		wr_done = psel & penable & pready & pwrite & ~pslverr;
		wr_ctrl = wr_done & hit_ctrl;
		wr_cause = wr_done & hit_cause;
		wd = pwdata[7:0];
	end

	// control register as software sees it
	always_comb
	begin
		ctrl_view = 8'h00;
		ctrl_view[IRQ_FLAG_BIT] = ctrl.irq_flag;
		ctrl_view[IRQ_EN_BIT] = irq_en_eff;
		ctrl_view[SEL_HI_BIT] = ctrl.timeout_select[SEL_W-1];
		ctrl_view[UNLOCK_BIT] = unlocked;
		ctrl_view[RST_EN_BIT] = rst_en_eff;
		ctrl_view[SEL_LO_MSB:0] = ctrl.timeout_select[SEL_LO_MSB:0];
	end

	// answer in the first access cycle
	always_comb
	begin
		next_pready = setup;
		next_pslverr = setup & ~(hit_ctrl | hit_cause);
		next_prdata = 32'h0000_0000;
		if (setup && !pwrite && hit_ctrl)
		begin
			next_prdata = {24'h00_0000, ctrl_view};
		end
		else if (setup && !pwrite && hit_cause)
		begin
			next_prdata = {27'h000_0000, cause};
		end
	end

	// bus answer registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// control register and unlock window
	////////////////////////////////////////////////////////////////

	// software writes, vector acknowledge, then hardware events
	always_comb
	begin
		next_ctrl = ctrl;
		next_unlock_count = unlocked ? unlock_count - 3'h1 : 3'h0;
		if (wr_ctrl)
		begin
			if (wd[IRQ_FLAG_BIT])
			begin
				next_ctrl.irq_flag = 1'b0;
			end
			next_ctrl.irq_enable = wd[IRQ_EN_BIT] & ~always_on_fuse;
			if (wd[RST_EN_BIT])
			begin
				next_ctrl.reset_enable = 1'b1;
			end
			else if (unlocked && !cause[DOG_BIT])
			begin
				next_ctrl.reset_enable = 1'b0;
			end
			if (unlocked)
			begin
				next_ctrl.timeout_select = {wd[SEL_HI_BIT], wd[SEL_LO_MSB:0]};
			end
			if (wd[UNLOCK_BIT] && wd[RST_EN_BIT])
			begin
				next_unlock_count = 3'(UNLOCK_CYCLES);
			end
			else
			begin
				next_unlock_count = 3'h0;
			end
		end
		if (vector_ack)
		begin
			next_ctrl.irq_flag = 1'b0;
			if (rst_en_eff)
			begin
				next_ctrl.irq_enable = 1'b0;
			end
		end
		// a timeout set wins over a write or vector clear in the same cycle
		if (do_irq)
		begin
			next_ctrl.irq_flag = 1'b1;
		end
		if (any_reset)
		begin
			next_ctrl = CTRL_RESET;
			next_unlock_count = 3'h0;
		end
	end

	// control registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl <= CTRL_RESET;
			unlock_count <= 3'h0;
		end
		else
		begin
			ctrl <= next_ctrl;
			unlock_count <= next_unlock_count;
		end
	end

	////////////////////////////////////////////////////////////////
	// reset-cause register
	////////////////////////////////////////////////////////////////

	// writing zero clears a flag; events set and win
	always_comb
	begin
		next_cause = cause;
		if (wr_cause)
		begin
			next_cause = cause & wd[4:0];
		end
		if (reset_event.jtag)
		begin
			next_cause[JTAG_BIT] = 1'b1;
		end
		if (do_reset)
		begin
			next_cause[DOG_BIT] = 1'b1;
		end
		if (reset_event.brownout)
		begin
			next_cause[BROWN_BIT] = 1'b1;
		end
		if (reset_event.pin)
		begin
			next_cause[PIN_BIT] = 1'b1;
		end
	end

	// power-on clears all but the power-on flag, which it sets
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cause <= CAUSE_RESET;
		end
		else
		begin
			cause <= next_cause;
		end
	end

	////////////////////////////////////////////////////////////////
	// interrupt request and reset pulse
	////////////////////////////////////////////////////////////////

	// request needs the flag and both enables
	always_comb
	begin
		next_timeout_irq = next_ctrl.irq_flag & next_ctrl.irq_enable
			& ~always_on_fuse & global_irq_enable;
		next_dog_system_reset = do_reset;
	end

	// output registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			timeout_irq <= 1'b0;
			dog_system_reset <= 1'b0;
		end
		else
		begin
			timeout_irq <= next_timeout_irq;
			dog_system_reset <= next_dog_system_reset;
		end
	end

endmodule

// ### wdog_top_monitor.sv
/*
 port checker for wdog_top.
 bound from the test top; one pclk domain.
*/
`timescale 1ns/100ps
module wdog_top_monitor
	import wdog_pkg::*;
#(
	parameter int DIV = OSC_DIV
)(
	input wire logic	pclk,
	input wire logic	presetn,
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [ADDR_W-1:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic [31:0]	prdata,
	input wire logic	pready,
	input wire logic	pslverr,
	input wire logic	always_on_fuse,
	input wire logic	global_irq_enable,
	input wire logic	vector_ack,
	input wire logic	restart,
	input wire wdog_pkg::reset_event_t	reset_event,
	input wire logic	timeout_irq,
	input wire logic	dog_system_reset
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	// bus answer
	ready_pulse_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not one cycle");
	bad_addr_a: assert property (pslverr |-> pready && paddr != CTRL_ADDR && paddr != CAUSE_ADDR)
		else $error("pslverr on mapped address");
	idle_data_a: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero when idle");
	high_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	////////////////////////////////////////////////////////////////
	// interrupt and reset outputs
	irq_gate_a: assert property (timeout_irq |-> $past(global_irq_enable))
		else $error("irq without global enable");
	irq_ack_a: assert property (vector_ack && timeout_irq |=> ##1 !timeout_irq)
		else $error("irq kept after vector");
	rst_pulse_a: assert property (dog_system_reset |=> !dog_system_reset)
		else $error("reset pulse too long");
	fuse_irq_a: assert property (always_on_fuse |-> !timeout_irq)
		else $error("irq with fuse set");
	fuse_read_a: assert property (pready && !pwrite && always_on_fuse
		&& paddr == CTRL_ADDR |-> prdata[3])
		else $error("reset enable not forced");
	// main scenarios reached
	cover property (vector_ack && timeout_irq);
	cover property (dog_system_reset);
	cover property (pslverr);
endmodule

// ### wdog_top_test.sv
/*
 self-checking test of wdog_top over apb.
 uses wdog_cpu_model and wdog_top_monitor.
*/
`timescale 1ns/100ps
module wdog_top_test;
	import wdog_pkg::*;
	logic	pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic	fuse, gie, vack, restart, service, irq, dreset;
	logic [11:0]	paddr;
	logic [31:0]	pwdata, prdata, q;
	logic [7:0]	lat;
	reset_event_t	ev;
	int	n_fail, check_count, cyc, n_rst, t0;

	wdog_top #(.DIV(1)) u_wdog_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .always_on_fuse(fuse), .global_irq_enable(gie),
		.vector_ack(vack), .restart(restart), .reset_event(ev), .timeout_irq(irq),
		.dog_system_reset(dreset));
	wdog_cpu_model u_wdog_cpu_model (.pclk(pclk), .presetn(presetn), .timeout_irq(irq),
		.service(service), .lat(lat), .vector_ack(vack));

	////////////////////////////////////////////////////////////////
	// clock, hang limit and reset pulse count
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cyc++;
		if (dreset === 1'b1)
			n_rst++;
		if (cyc == 40000)
		begin
			n_fail++;
			wrap_up();
		end
	end

	////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic wrap_up();
		if (n_fail == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// keep leaves psel up so the next setup follows at once
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d,
		input logic keep);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		err = pslverr;
		if (!keep)
		begin
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 8'h0, 1'b0);
		chk(q, exp);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		xfer(1'b1, a, d, 1'b0);
	endtask
	task automatic wait_irq(input logic v);
		while (irq !== v)
			@(posedge pclk);
	endtask
	task automatic reset_dut();
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask
	task automatic pulse_ev();
		ev <= '1;
		@(posedge pclk);
		ev <= '0;
		@(posedge pclk);
	endtask

	////////////////////////////////////////////////////////////////
	// scenarios
	task automatic s_regs();
		rd(CTRL_ADDR, 32'h0);
		rd(CAUSE_ADDR, 32'h1);
		rd(12'h068, 32'h0);
		chk({31'h0, err}, 32'h1);
		pulse_ev();
		rd(CAUSE_ADDR, 32'h17);
		wr(CAUSE_ADDR, 8'h00);
		rd(CAUSE_ADDR, 32'h0);
		pulse_ev();
		reset_dut();
		rd(CAUSE_ADDR, 32'h1);
		fuse <= 1'b1;
		wr(CTRL_ADDR, 8'h40);
		rd(CTRL_ADDR, 32'h8);
		fuse <= 1'b0;
		wr(CTRL_ADDR, 8'h00);
	endtask
	task automatic s_irq();
		restart <= 1'b1;
		@(posedge pclk);
		restart <= 1'b0;
		xfer(1'b1, CTRL_ADDR, 8'h18, 1'b1);
		wr(CTRL_ADDR, 8'h41);
		rd(CTRL_ADDR, 32'h41);
		repeat (3000) @(posedge pclk);
		restart <= 1'b1;
		@(posedge pclk);
		restart <= 1'b0;
		t0 = cyc;
		wait_irq(1'b1);
		chk({31'h0, (cyc - t0) inside {[4090:4110]}}, 32'h1);
		rd(CTRL_ADDR, 32'hc1);
		chk(n_rst, 0);
		wr(CTRL_ADDR, 8'hc1);
		rd(CTRL_ADDR, 32'h41);
		gie <= 1'b0;
		repeat (4200) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		rd(CTRL_ADDR, 32'hc1);
		gie <= 1'b1;
		wait_irq(1'b1);
		service <= 1'b1;
		wait_irq(1'b1);
		wait_irq(1'b0);
		rd(CTRL_ADDR, 32'h41);
		service <= 1'b0;
		xfer(1'b1, CTRL_ADDR, 8'h18, 1'b1);
		wr(CTRL_ADDR, 8'h00);
		repeat (2200) @(posedge pclk);
		chk({irq, 31'h0}, 32'h0);
		chk(n_rst, 0);
	endtask
	task automatic s_both();
		t0 = cyc;
		wr(CTRL_ADDR, 8'h48);
		wait_irq(1'b1);
		chk({31'h0, (cyc - t0) inside {[2040:2070]}}, 32'h1);
		rd(CTRL_ADDR, 32'hc8);
		while (dreset !== 1'b1)
			@(posedge pclk);
		@(posedge pclk);
		chk(n_rst, 1);
		rd(CTRL_ADDR, 32'h08);
		rd(CAUSE_ADDR, 32'h09);
		xfer(1'b1, CTRL_ADDR, 8'h18, 1'b1);
		wr(CTRL_ADDR, 8'h00);
		rd(CTRL_ADDR, 32'h08);
		wr(CAUSE_ADDR, 8'h01);
		wr(CTRL_ADDR, 8'h0d);
		rd(CTRL_ADDR, 32'h08);
		xfer(1'b1, CTRL_ADDR, 8'h18, 1'b1);
		rd(CTRL_ADDR, 32'h18);
		repeat (4) @(posedge pclk);
		rd(CTRL_ADDR, 32'h08);
		lat <= 8'h00;
		service <= 1'b1;
		wr(CTRL_ADDR, 8'h48);
		wait_irq(1'b1);
		wait_irq(1'b0);
		rd(CTRL_ADDR, 32'h08);
	endtask

	////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		{presetn, psel, penable, pwrite, fuse, restart, service} = '0;
		gie = 1'b1;
		paddr = '0;
		pwdata = '0;
		lat = 8'h03;
		ev = '0;
		{n_fail, check_count, cyc, n_rst} = '0;
		reset_dut();
		s_regs();
		s_irq();
		s_both();
		wrap_up();
	end
endmodule

bind wdog_top wdog_top_monitor #(.DIV(DIV)) u_wdog_top_monitor (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.always_on_fuse(always_on_fuse), .global_irq_enable(global_irq_enable),
	.vector_ack(vector_ack), .restart(restart), .reset_event(reset_event),
	.timeout_irq(timeout_irq), .dog_system_reset(dog_system_reset));
